// ===== core/dbl_vid_key_upper_fields.sv
// upper fields (bits 64..92) plus bits 23 and 63 of the double-vid quad key
`timescale 1ns/10ps
`default_nettype none

// Contract
// - overloaded 16-bit type field sits at key bit 64, chosen by frame type
// - llc frames: type field is destination sap then source sap
// - snap frames: type field is protocol id bytes 4 down to 3
// - ip tcp or udp frames: type field is layer-4 destination port
// - other ip frames: type field is the ip protocol number
// - arp and other type-encoded frames: type field is the ethertype
// - oam frames with ethertype 0x8902: upper type byte forced to 0x89
// - oam frames: type bit 7 set when injected with masquerading
// - oam frames: type bits 6..0 carry the meg level encoding
// - oam flag set whenever the type field holds the oam encoding
// - bit 80 set for ipv4, ipv6 or snap frames, else clear
// - bit 81 set only for ipv4 frames
// - bit 82 set when ipv4 more-fragments is set or offset nonzero
// - bit 83 set only for ipv4 fragments with offset above zero
// - bit 84 set when ipv4 header length exceeds five
// - options are not skipped; layer-4 data of such frames is untrusted
// - six-bit dscp after translation placed at key bit 85
// - bit 91 set for ipv4 or ipv6 frames carrying tcp or udp
// - bit 92 set only for ipv4 or ipv6 frames carrying tcp
// - oam flag at key bit 23 set for oam frames with ethertype 8902
// - bit 63 set when ethertype is at least 0x600, clear when length coded
module dbl_vid_key_upper_fields
  import key_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic inValid,
  input wire parsedHdr_t hdr,
  output logic keyValid_q,
  output var keyUpper_t keyUpper_q,
  output logic oamFrameFlag_q,
  output logic typeEncodedFlag_q,
  output logic l4Untrusted_q
);

  ////////////////////////////////////////////////////////////////////////////
  // frame classification

  wire logic typeEncoded;
  wire logic snapHeader;
  wire logic isIpv4;
  wire logic isIpv6;
  wire logic isIp;
  wire logic isOam;
  wire logic isTcp;
  wire logic isUdp;
  wire frameClass_t frameClass;

  assign typeEncoded = (hdr.etherType >= TYPE_MIN_ETHERTYPE);
  // a length-coded frame is snap only with the aa-aa-03 header, otherwise plain llc
  assign snapHeader = (hdr.llcDsap == SNAP_SAP) && (hdr.llcSsap == SNAP_SAP) &&
                      (hdr.llcCtrl == SNAP_CTRL);
  assign isIpv4 = typeEncoded && (hdr.etherType == TYPE_IPV4);
  assign isIpv6 = typeEncoded && (hdr.etherType == TYPE_IPV6);
  assign isIp = isIpv4 || isIpv6;
  assign isOam = typeEncoded && (hdr.etherType == TYPE_OAM);
  assign isTcp = isIp && (hdr.ipProto == PROTO_TCP);
  assign isUdp = isIp && (hdr.ipProto == PROTO_UDP);

  assign frameClass =
      !typeEncoded ? (snapHeader ? FR_SNAP : FR_LLC) :
      isIpv4 ? FR_IPV4 :
      isIpv6 ? FR_IPV6 :
      isOam ? FR_OAM :
      (hdr.etherType == TYPE_ARP) ? FR_ARP :
      FR_OTHER_TYPE;

  ////////////////////////////////////////////////////////////////////////////
  // field builders

  wire logic transportPortFlag;
  wire logic tcpFlag;
  wire logic ipOrSnapFlag;
  wire logic [15:0] overloadedTypeField;
  wire logic fragmentedFlag;
  wire logic laterFragmentFlag;
  wire logic ipv4OptionsFlag;
  wire logic l4Untrusted;

  assign transportPortFlag = isTcp || isUdp;
  assign tcpFlag = isTcp;
  assign ipOrSnapFlag = isIp || (frameClass == FR_SNAP);

  type_field_mux type_field_mux_i (
    .frameClass(frameClass),
    .hdr(hdr),
    .transportPortFlag(transportPortFlag),
    .overloadedTypeField(overloadedTypeField)
  );

  ipv4_frag_flags ipv4_frag_flags_i (
    .ipv4Frame(isIpv4),
    .moreFrag(hdr.ipv4MoreFrag),
    .fragOfs(hdr.ipv4FragOfs),
    .ihl(hdr.ipv4Ihl),
    .fragmentedFlag(fragmentedFlag),
    .laterFragmentFlag(laterFragmentFlag),
    .ipv4OptionsFlag(ipv4OptionsFlag),
    .l4Untrusted(l4Untrusted)
  );

  ////////////////////////////////////////////////////////////////////////////
  // key assembly

  keyUpper_t keyUpper_d;
  keyUpper_t keyNew;
  logic oamFrameFlag_d;
  logic typeEncodedFlag_d;
  logic l4Untrusted_d;

  assign keyNew.tcpFlag = tcpFlag;
  assign keyNew.transportPortFlag = transportPortFlag;
  assign keyNew.diffservCodeField = hdr.dscp;
  assign keyNew.ipv4OptionsFlag = ipv4OptionsFlag;
  assign keyNew.laterFragmentFlag = laterFragmentFlag;
  assign keyNew.fragmentedFlag = fragmentedFlag;
  assign keyNew.ipv4FrameFlag = isIpv4;
  assign keyNew.ipOrSnapFlag = ipOrSnapFlag;
  assign keyNew.overloadedTypeField = overloadedTypeField;

  // the key holds its last value between frames so the match stage sees no glitch
  assign keyUpper_d = inValid ? keyNew : keyUpper_q;
  assign oamFrameFlag_d = inValid ? (frameClass == FR_OAM) : oamFrameFlag_q;
  assign typeEncodedFlag_d = inValid ? typeEncoded : typeEncodedFlag_q;
  assign l4Untrusted_d = inValid ? l4Untrusted : l4Untrusted_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      keyValid_q <= 1'b0;
      keyUpper_q <= '0;
      oamFrameFlag_q <= 1'b0;
      typeEncodedFlag_q <= 1'b0;
      l4Untrusted_q <= 1'b0;
    end else begin
      keyValid_q <= inValid;
      keyUpper_q <= keyUpper_d;
      oamFrameFlag_q <= oamFrameFlag_d;
      typeEncodedFlag_q <= typeEncodedFlag_d;
      l4Untrusted_q <= l4Untrusted_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  wire logic [15:0] llcWordChk;
  wire logic [15:0] snapWordChk;
  wire logic [15:0] protoWordChk;
  // raw header terms, kept apart from the classifier so the checks do not mirror it
  wire logic ipChk;
  wire logic snapChk;

  assign llcWordChk = {hdr.llcDsap, hdr.llcSsap};
  assign snapWordChk = {hdr.snapPid[SNAP_PID_HI], hdr.snapPid[SNAP_PID_LO]};
  assign protoWordChk = {PROTO_PAD, hdr.ipProto};
  assign ipChk = (hdr.etherType == TYPE_IPV4) || (hdr.etherType == TYPE_IPV6);
  assign snapChk = (hdr.etherType < TYPE_MIN_ETHERTYPE) && (hdr.llcDsap == SNAP_SAP) &&
                   (hdr.llcSsap == SNAP_SAP) && (hdr.llcCtrl == SNAP_CTRL);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_take_llc;
    inValid && (hdr.etherType < TYPE_MIN_ETHERTYPE) && !snapHeader;
  endsequence

  sequence s_take_snap;
    inValid && (hdr.etherType < TYPE_MIN_ETHERTYPE) && snapHeader;
  endsequence

  sequence s_take_ip_l4;
    inValid && (hdr.etherType == TYPE_IPV4 || hdr.etherType == TYPE_IPV6) &&
    (hdr.ipProto == PROTO_TCP || hdr.ipProto == PROTO_UDP);
  endsequence

  sequence s_take_ip_other;
    inValid && (hdr.etherType == TYPE_IPV4 || hdr.etherType == TYPE_IPV6) &&
    !(hdr.ipProto == PROTO_TCP || hdr.ipProto == PROTO_UDP);
  endsequence

  sequence s_take_oam;
    inValid && (hdr.etherType == TYPE_OAM);
  endsequence

  sequence s_key_out;
    keyValid_q;
  endsequence

  property p_llc_field;
    s_take_llc |=> s_key_out ##0
      (keyUpper_q.overloadedTypeField == $past(llcWordChk)) && !keyUpper_q.ipOrSnapFlag;
  endproperty
  a_llc_field: assert property (p_llc_field)
    else $error("llc type field wrong");

  property p_snap_field;
    s_take_snap |=> s_key_out ##0
      (keyUpper_q.overloadedTypeField == $past(snapWordChk)) && keyUpper_q.ipOrSnapFlag;
  endproperty
  a_snap_field: assert property (p_snap_field)
    else $error("snap type field wrong");

  property p_ip_port;
    s_take_ip_l4 |=> s_key_out ##0
      (keyUpper_q.overloadedTypeField == $past(hdr.l4DstPort)) &&
      keyUpper_q.transportPortFlag;
  endproperty
  a_ip_port: assert property (p_ip_port)
    else $error("ip transport_port_flag type field is not the destination port");

  property p_ip_proto;
    s_take_ip_other |=> s_key_out ##0
      (keyUpper_q.overloadedTypeField == $past(protoWordChk)) &&
      !keyUpper_q.transportPortFlag && !keyUpper_q.tcpFlag;
  endproperty
  a_ip_proto: assert property (p_ip_proto)
    else $error("ip other type field is not the protocol");

  property p_plain_type;
    inValid && typeEncoded && !isIp && !isOam |=>
      keyUpper_q.overloadedTypeField == $past(hdr.etherType);
  endproperty
  a_plain_type: assert property (p_plain_type)
    else $error("type-encoded frame does not carry its ethertype");

  property p_oam_field;
    s_take_oam |=> oamFrameFlag_q &&
      (keyUpper_q.overloadedTypeField[15:8] == OAM_UPPER_BYTE) &&
      (keyUpper_q.overloadedTypeField[7] == $past(hdr.oamMasq)) &&
      (keyUpper_q.overloadedTypeField[6:0] == $past(hdr.oamMelCode));
  endproperty
  a_oam_field: assert property (p_oam_field)
    else $error("oam encoding wrong");

  property p_oam_flag_only;
    inValid && !isOam |=> !oamFrameFlag_q;
  endproperty
  a_oam_flag_only: assert property (p_oam_flag_only)
    else $error("oam flag set for a non-oam frame");

  property p_ipv4_flags;
    inValid |=> (keyUpper_q.ipv4FrameFlag == $past(hdr.etherType == TYPE_IPV4)) &&
      (keyUpper_q.ipOrSnapFlag == $past(ipChk || snapChk));
  endproperty
  a_ipv4_flags: assert property (p_ipv4_flags)
    else $error("frame type flags wrong");

  property p_frag;
    inValid && isIpv4 && (hdr.ipv4MoreFrag || hdr.ipv4FragOfs != FRAG_OFS_ZERO) |=>
      keyUpper_q.fragmentedFlag && l4Untrusted_q;
  endproperty
  a_frag: assert property (p_frag)
    else $error("fragment flag missing");

  property p_later_frag;
    inValid && isIpv4 |=>
      keyUpper_q.laterFragmentFlag == ($past(hdr.ipv4FragOfs) != FRAG_OFS_ZERO);
  endproperty
  a_later_frag: assert property (p_later_frag)
    else $error("later fragment flag wrong");

  property p_options;
    inValid && isIpv4 |=>
      keyUpper_q.ipv4OptionsFlag == ($past(hdr.ipv4Ihl) > IHL_NO_OPTIONS);
  endproperty
  a_options: assert property (p_options)
    else $error("options flag wrong");

  property p_dscp;
    inValid |=> keyUpper_q.diffservCodeField == $past(hdr.dscp);
  endproperty
  a_dscp: assert property (p_dscp)
    else $error("dscp not carried");

  property p_tcp;
    inValid |=> (keyUpper_q.tcpFlag == $past(ipChk && (hdr.ipProto == PROTO_TCP))) &&
      (!keyUpper_q.tcpFlag || keyUpper_q.transportPortFlag);
  endproperty
  a_tcp: assert property (p_tcp)
    else $error("tcp flag wrong");

  property p_type_encoded;
    inValid |=> typeEncodedFlag_q == ($past(hdr.etherType) >= TYPE_MIN_ETHERTYPE);
  endproperty
  a_type_encoded: assert property (p_type_encoded)
    else $error("type-encoded flag wrong");

  property p_non_ipv4_clear;
    s_key_out ##0 !keyUpper_q.ipv4FrameFlag |->
      !keyUpper_q.fragmentedFlag && !keyUpper_q.laterFragmentFlag &&
      !keyUpper_q.ipv4OptionsFlag && !l4Untrusted_q;
  endproperty
  a_non_ipv4_clear: assert property (p_non_ipv4_clear)
    else $error("ipv4 flags set on a non-ipv4 frame");

  property p_non_ip_l4_clear;
    inValid && !isIp |=> !keyUpper_q.transportPortFlag && !keyUpper_q.tcpFlag;
  endproperty
  a_non_ip_l4_clear: assert property (p_non_ip_l4_clear)
    else $error("layer-4 flags set on a non-ip frame");

  property p_hold_idle;
    !inValid |=> !keyValid_q && $stable(keyUpper_q) && $stable(oamFrameFlag_q);
  endproperty
  a_hold_idle: assert property (p_hold_idle)
    else $error("key changed without a frame");

  property p_key_valid;
    inValid |=> s_key_out;
  endproperty
  a_key_valid: assert property (p_key_valid)
    else $error("key valid missing after a frame");

  property p_untrusted;
    s_key_out |-> l4Untrusted_q == (keyUpper_q.fragmentedFlag || keyUpper_q.ipv4OptionsFlag);
  endproperty
  a_untrusted: assert property (p_untrusted)
    else $error("untrusted layer-4 flag disagrees with fragment and options flags");

  property p_unfragmented;
    inValid && !hdr.ipv4MoreFrag && (hdr.ipv4FragOfs == FRAG_OFS_ZERO) |=>
      !keyUpper_q.fragmentedFlag && !keyUpper_q.laterFragmentFlag;
  endproperty
  a_unfragmented: assert property (p_unfragmented)
    else $error("fragment flag set on an unfragmented frame");

  property p_later_implies_frag;
    s_key_out ##0 keyUpper_q.laterFragmentFlag |-> keyUpper_q.fragmentedFlag;
  endproperty
  a_later_implies_frag: assert property (p_later_implies_frag)
    else $error("later fragment without fragment flag");

  property p_l4_needs_ip;
    s_key_out ##0 keyUpper_q.transportPortFlag |-> keyUpper_q.ipOrSnapFlag &&
      !oamFrameFlag_q && typeEncodedFlag_q;
  endproperty
  a_l4_needs_ip: assert property (p_l4_needs_ip)
    else $error("transport flag on a frame that is not ip");

  property p_length_coded;
    inValid && (hdr.etherType < TYPE_MIN_ETHERTYPE) |=>
      !typeEncodedFlag_q && !oamFrameFlag_q && !keyUpper_q.ipv4FrameFlag;
  endproperty
  a_length_coded: assert property (p_length_coded)
    else $error("type flags set on a length-coded frame");

endmodule : dbl_vid_key_upper_fields

`default_nettype wire

// ===== core/key_pkg.sv
// constants and carrier types for the upper fields of the double-vid quad key
package key_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // key bit positions
  localparam int KEY_OAM_FLAG_BIT = 23;
  localparam int KEY_TYPE_ENCODED_BIT = 63;
  localparam int KEY_UPPER_LSB = 64;
  localparam int KEY_UPPER_MSB = 92;
  localparam int KEY_UPPER_W = KEY_UPPER_MSB - KEY_UPPER_LSB + 1;

  ////////////////////////////////////////////////////////////////////////////
  // ethertype and header constants
  localparam logic [15:0] TYPE_MIN_ETHERTYPE = 16'h0600;
  localparam logic [15:0] TYPE_IPV4 = 16'h0800;
  localparam logic [15:0] TYPE_IPV6 = 16'h86dd;
  localparam logic [15:0] TYPE_ARP = 16'h0806;
  localparam logic [15:0] TYPE_OAM = 16'h8902;
  localparam logic [7:0] OAM_UPPER_BYTE = 8'h89;
  localparam logic [7:0] SNAP_SAP = 8'haa;
  localparam logic [7:0] SNAP_CTRL = 8'h03;
  // protocol id bytes that land in the type field of a snap frame
  localparam int SNAP_PID_HI = 4;
  localparam int SNAP_PID_LO = 3;
  localparam logic [7:0] PROTO_TCP = 8'h06;
  localparam logic [7:0] PROTO_UDP = 8'h11;
  localparam logic [7:0] PROTO_PAD = 8'h00;
  localparam logic [3:0] IHL_NO_OPTIONS = 4'h5;
  localparam logic [12:0] FRAG_OFS_ZERO = 13'h0000;
  localparam logic [15:0] TYPE_FIELD_RESET = 16'h0000;
  localparam logic [5:0] DSCP_RESET = 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    FR_LLC, FR_SNAP, FR_IPV4, FR_IPV6, FR_ARP, FR_OAM, FR_OTHER_TYPE
  } frameClass_t;

  // fields handed over by the frame parser and basic classifier
  typedef struct packed {
    logic [15:0] etherType;
    logic [7:0] llcDsap;
    logic [7:0] llcSsap;
    logic [7:0] llcCtrl;
    logic [4:0][7:0] snapPid;
    logic [7:0] ipProto;
    logic [3:0] ipv4Ihl;
    logic ipv4MoreFrag;
    logic [12:0] ipv4FragOfs;
    logic [15:0] l4DstPort;
    logic [5:0] dscp;
    logic oamMasq;
    logic [6:0] oamMelCode;
  } parsedHdr_t;

  // key bits 92 down to 64, msb first
  typedef struct packed {
    logic tcpFlag;
    logic transportPortFlag;
    logic [5:0] diffservCodeField;
    logic ipv4OptionsFlag;
    logic laterFragmentFlag;
    logic fragmentedFlag;
    logic ipv4FrameFlag;
    logic ipOrSnapFlag;
    logic [15:0] overloadedTypeField;
  } keyUpper_t;

endpackage : key_pkg

// ===== core/type_field_mux.sv
// selection of the 16-bit overloaded type field by frame class
`timescale 1ns/10ps
`default_nettype none

module type_field_mux
  import key_pkg::*;
(
  input wire frameClass_t frameClass,
  input wire parsedHdr_t hdr,
  input wire logic transportPortFlag,
  output logic [15:0] overloadedTypeField
);

  wire logic [15:0] llcWord;
  wire logic [15:0] snapWord;
  wire logic [15:0] ipWord;
  wire logic [15:0] oamWord;

  assign llcWord = {hdr.llcDsap, hdr.llcSsap};
  assign snapWord = {hdr.snapPid[SNAP_PID_HI], hdr.snapPid[SNAP_PID_LO]};
  // port numbers are taken as the parser found them, options are not skipped
  assign ipWord = transportPortFlag ? hdr.l4DstPort : {PROTO_PAD, hdr.ipProto};
  assign oamWord = {OAM_UPPER_BYTE, hdr.oamMasq, hdr.oamMelCode};

  assign overloadedTypeField =
      (frameClass == FR_LLC) ? llcWord :
      (frameClass == FR_SNAP) ? snapWord :
      (frameClass == FR_IPV4 || frameClass == FR_IPV6) ? ipWord :
      (frameClass == FR_OAM) ? oamWord :
      hdr.etherType;

endmodule : type_field_mux

`default_nettype wire

// ===== core/ipv4_frag_flags.sv
// ipv4 fragment and option flags, gated to ipv4 frames
`timescale 1ns/10ps
`default_nettype none

module ipv4_frag_flags
  import key_pkg::*;
(
  input wire logic ipv4Frame,
  input wire logic moreFrag,
  input wire logic [12:0] fragOfs,
  input wire logic [3:0] ihl,
  output logic fragmentedFlag,
  output logic laterFragmentFlag,
  output logic ipv4OptionsFlag,
  output logic l4Untrusted
);

  wire logic ofsNonZero;

  assign ofsNonZero = (fragOfs != FRAG_OFS_ZERO);
  assign fragmentedFlag = ipv4Frame && (moreFrag || ofsNonZero);
  assign laterFragmentFlag = ipv4Frame && ofsNonZero;
  assign ipv4OptionsFlag = ipv4Frame && (ihl > IHL_NO_OPTIONS);
  // options are neither skipped nor decoded, so layer-4 fields then sit at the wrong offset
  assign l4Untrusted = fragmentedFlag || ipv4OptionsFlag;

endmodule : ipv4_frag_flags

`default_nettype wire

// ===== tb/frame_parser_model.sv
// behavioural frame parser that hands shaped header fields to the key block
`timescale 1ns/10ps
`default_nettype none

module frame_parser_model
  import key_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic go,
  input wire logic [2:0] kind,
  input wire logic [159:0] rnd,
  output var logic inValid,
  output var parsedHdr_t hdr
);
  ////////////////////////////////////////////////////////////////////////////
  // kind: 0 llc, 1 snap, 2 ipv4, 3 ipv6, 4 arp, 5 oam, 6 plain type, 7 longest length
  function automatic parsedHdr_t shape(input logic [2:0] k, input logic [159:0] r);
    parsedHdr_t h;
    h = r[135:0];
    // fragment offset, more-fragments and header length each keep their random value only half the time
    if (!r[140]) h.ipv4FragOfs = FRAG_OFS_ZERO;
    if (!r[141]) h.ipv4MoreFrag = 1'b0;
    if (!r[142]) h.ipv4Ihl = IHL_NO_OPTIONS;
    if (r[145:144] == 2'h0) h.ipProto = PROTO_TCP;
    if (r[145:144] == 2'h1) h.ipProto = PROTO_UDP;
    case (k)
      3'h0: h.etherType = {6'h00, r[9:0]};
      3'h1: begin
        h.etherType = {6'h00, r[9:0]};
        h.llcDsap = SNAP_SAP;
        h.llcSsap = SNAP_SAP;
        h.llcCtrl = SNAP_CTRL;
      end
      3'h2: h.etherType = TYPE_IPV4;
      3'h3: h.etherType = TYPE_IPV6;
      3'h4: h.etherType = TYPE_ARP;
      3'h5: h.etherType = TYPE_OAM;
      // lowest type value comes up often
      3'h6: h.etherType = {8'h06, r[150] ? r[157:150] : 8'h00};
      default: h.etherType = 16'h05ff;
    endcase
    return h;
  endfunction : shape

  // idle fields are inverted so stale values never look valid
  always @(posedge clock) begin
    inValid <= go & !rst;
    if (go) begin
      hdr <= shape(kind, rnd);
    end else if (rst) begin
      hdr <= '0;
    end else begin
      hdr <= ~hdr;
    end
  end
endmodule : frame_parser_model

`default_nettype wire

// ===== tb/dbl_vid_key_upper_fields_test.sv
// self-checking bench for the upper key fields with a reference model
`timescale 1ns/10ps
`default_nettype none

module dbl_vid_key_upper_fields_test
  import key_pkg::*;
;
  localparam int CYCLE_LIMIT = 3000;
  logic clock, rst, go, inValid, keyValid_q, oamFrameFlag_q, typeEncodedFlag_q, l4Untrusted_q;
  logic [2:0] kind;
  logic [159:0] rnd, rndNext;
  logic [31:0] seed;
  parsedHdr_t hdr;
  keyUpper_t keyUpper_q, expKey;
  logic expValid;
  logic [2:0] expExtra;
  int failCount, checksDone, cycles;

  frame_parser_model frame_parser_model_i (.clock(clock), .rst(rst), .go(go), .kind(kind),
    .rnd(rnd), .inValid(inValid), .hdr(hdr));

  dbl_vid_key_upper_fields dbl_vid_key_upper_fields_i (.clock(clock), .rst(rst),
    .inValid(inValid), .hdr(hdr), .keyValid_q(keyValid_q), .keyUpper_q(keyUpper_q),
    .oamFrameFlag_q(oamFrameFlag_q), .typeEncodedFlag_q(typeEncodedFlag_q),
    .l4Untrusted_q(l4Untrusted_q));

  ////////////////////////////////////////////////////////////////////////////
  // reference model
  function automatic keyUpper_t model_key(input parsedHdr_t h);
    keyUpper_t k;
    int isV4, isIp, isSnap, isL4;
    isSnap = h.etherType < 16'h0600 && h.llcDsap == 8'haa && h.llcSsap == 8'haa
      && h.llcCtrl == 8'h03;
    isV4 = h.etherType == 16'h0800;
    isIp = isV4 || h.etherType == 16'h86dd;
    isL4 = isIp && (h.ipProto == 8'h06 || h.ipProto == 8'h11);
    k = '0;
    if (h.etherType < 16'h0600) k.overloadedTypeField = isSnap ?
      {h.snapPid[4], h.snapPid[3]} : {h.llcDsap, h.llcSsap};
    else if (isL4) k.overloadedTypeField = h.l4DstPort;
    else if (isIp) k.overloadedTypeField = {8'h00, h.ipProto};
    else if (h.etherType == 16'h8902) k.overloadedTypeField = {8'h89, h.oamMasq, h.oamMelCode};
    else k.overloadedTypeField = h.etherType;
    k.ipOrSnapFlag = isIp || isSnap;
    k.ipv4FrameFlag = isV4;
    k.fragmentedFlag = isV4 && (h.ipv4MoreFrag || h.ipv4FragOfs != 13'h0000);
    k.laterFragmentFlag = isV4 && h.ipv4FragOfs != 13'h0000;
    k.ipv4OptionsFlag = isV4 && h.ipv4Ihl > 4'h5;
    k.diffservCodeField = h.dscp;
    k.transportPortFlag = isL4;
    k.tcpFlag = isIp && h.ipProto == 8'h06;
    return k;
  endfunction : model_key

  // oam flag, type-encoded flag, untrusted layer-4 flag
  function automatic logic [2:0] model_extra(input parsedHdr_t h);
    keyUpper_t k;
    k = model_key(h);
    return {h.etherType == 16'h8902, h.etherType >= 16'h0600,
      k.fragmentedFlag | k.ipv4OptionsFlag};
  endfunction : model_extra

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
  endfunction : lfsr_next

  always @(posedge clock) begin
    if (rst) begin
      expValid <= 1'b0;
      expKey <= '0;
      expExtra <= 3'h0;
    end else begin
      expValid <= inValid;
      if (inValid) begin
        expKey <= model_key(hdr);
        expExtra <= model_extra(hdr);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  task automatic check(input logic [15:0] got, input logic [15:0] want, input string what);
    checksDone++;
    if (got !== want) begin
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, want);
      failCount++;
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  // outputs settle after the rising edge; compare on the falling one
  always @(negedge clock) begin
    if (cycles > 0) begin
      check(keyValid_q, expValid, "key valid");
      check(keyUpper_q[15:8], expKey[15:8], "type hi");
      check(keyUpper_q[7:0], expKey[7:0], "type lo");
      check(keyUpper_q.ipOrSnapFlag, expKey.ipOrSnapFlag, "ip or snap");
      check(keyUpper_q.ipv4FrameFlag, expKey.ipv4FrameFlag, "ipv4");
      check(keyUpper_q.fragmentedFlag, expKey.fragmentedFlag, "fragment");
      check(keyUpper_q.laterFragmentFlag, expKey.laterFragmentFlag, "later");
      check(keyUpper_q.ipv4OptionsFlag, expKey.ipv4OptionsFlag, "options");
      check(keyUpper_q.diffservCodeField, expKey.diffservCodeField, "dscp");
      check(keyUpper_q.transportPortFlag, expKey.transportPortFlag, "l4");
      check(keyUpper_q.tcpFlag, expKey.tcpFlag, "tcp");
      check(oamFrameFlag_q, expExtra[2], "oam flag");
      check(typeEncodedFlag_q, expExtra[1], "type encoded");
      check(l4Untrusted_q, expExtra[0], "untrusted");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock, timeout and stimulus
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == CYCLE_LIMIT) begin
      failCount++;
      print_verdict();
    end
  end

  initial begin
    rst = 1'b1;
    go = 1'b0;
    kind = 3'h0;
    rnd = '0;
    seed = 32'h000177af;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 400; i++) begin
      if (i == 200) begin
        // reset in mid-run clears every key output
        rst <= 1'b1;
        go <= 1'b0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
      end
      for (int w = 0; w < 5; w++) begin
        seed = lfsr_next(seed);
        rndNext[w * 32 +: 32] = seed;
      end
      rnd <= rndNext;
      kind <= (i < 8) ? 3'(i) : rndNext[154:152];
      go <= 1'b1;
      @(posedge clock);
      if (rndNext[159]) begin
        go <= 1'b0;
        @(posedge clock);
      end
    end
    go <= 1'b0;
    repeat (4) @(posedge clock);
    print_verdict();
  end
endmodule : dbl_vid_key_upper_fields_test

`default_nettype wire
